// ===== pkg/fsr_pkg.sv
// Constants and types shared by the FEC status readback bank
package fsr_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int F1_W = 24;
	localparam int F2_W = 20;
	localparam int F2_PAD_W = 4;
	localparam int SQ_W = 24;
	localparam int RATE_W = 3;
	localparam int RSCNT_W = 4;
	localparam int LOCK_N = 3;
	localparam int EVT_W = 4;
	localparam int LOCK_NODE = 0;
	localparam int LOCK_FRAME = 1;
	localparam int LOCK_BYTE = 2;
	localparam int EVT_BLOCK = 3;
	localparam logic [ADDR_W-1:0] OFS_F1_HI = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_F1_MID = 8'h11;
	localparam logic [ADDR_W-1:0] OFS_F1_LO = 8'h12;
	localparam logic [ADDR_W-1:0] OFS_F2_HI = 8'h13;
	localparam logic [ADDR_W-1:0] OFS_F2_MID = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_F2_LO = 8'h15;
	localparam logic [ADDR_W-1:0] OFS_SQ_HI = 8'h16;
	localparam logic [ADDR_W-1:0] OFS_SQ_MID = 8'h17;
	localparam logic [ADDR_W-1:0] OFS_SQ_LO = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_RATE = 8'h19;
	localparam logic [ADDR_W-1:0] OFS_RSCNT = 8'h1a;
	localparam logic [ADDR_W-1:0] OFS_LOCK = 8'h1b;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 8'h21;
	localparam logic [ADDR_W-1:0] OFS_IRQ_CLR = 8'h22;
	localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
	localparam logic [RSCNT_W-1:0] RSCNT_MAX = 4'h8;
	localparam logic [RSCNT_W-1:0] RSCNT_ZERO = 4'h0;
	localparam logic [F2_PAD_W-1:0] F2_PAD = 4'h0;
	typedef enum logic [RATE_W-1:0] {
		FSR_RATE_1_2 = 3'h0,
		FSR_RATE_2_3 = 3'h1,
		FSR_RATE_3_4 = 3'h2,
		FSR_RATE_5_6 = 3'h3,
		FSR_RATE_7_8 = 3'h4
	} fsr_rate_t;
endpackage : fsr_pkg

// ===== hw/fsr_evt_detect.sv
// Per-bit change detector turning lock levels into one-cycle events
`timescale 1ns/1ns
module fsr_evt_detect #(
	parameter int W = 3
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] lvl,
	output logic [W-1:0] chg
);
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic prev_r;
			logic chg_r;
			always_ff @(posedge clk) begin
				if (rst) begin
					prev_r <= 1'b0;
					chg_r <= 1'b0;
				end else begin
					prev_r <= lvl[i];
					chg_r <= lvl[i] ^ prev_r;
				end
			end
			assign chg[i] = chg_r;
		end
	endgenerate
endmodule : fsr_evt_detect

// ===== hw/fsr_irq_ctrl.sv
// Sticky event status, enable mask and level interrupt
`timescale 1ns/1ns
module fsr_irq_ctrl #(
	parameter int W = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] evt,
	input wire logic en_wr,
	input wire logic clr_wr,
	input wire logic [W-1:0] wdata,
	output logic [W-1:0] status,
	output logic [W-1:0] enable,
	output logic irq
);
	logic [W-1:0] status_r;
	logic [W-1:0] enable_r;
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			// A new event wins over a clear in the same cycle
			always_ff @(posedge clk) begin
				if (rst) begin
					status_r[i] <= 1'b0;
				end else if (evt[i]) begin
					status_r[i] <= 1'b1;
				end else if (clr_wr && wdata[i]) begin
					status_r[i] <= 1'b0;
				end
			end
		end
	endgenerate
	always_ff @(posedge clk) begin
		if (rst) begin
			enable_r <= '0;
		end else if (en_wr) begin
			enable_r <= wdata;
		end
	end
	assign status = status_r;
	assign enable = enable_r;
	assign irq = |(status_r & enable_r);

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	evt_sets_irq_a: assert property (evt[0] && enable_r[0] |=> irq)
		else $error("enabled event did not raise interrupt");
	set_beats_clear_a: assert property (evt[0] && clr_wr |=> status_r[0])
		else $error("clear beat a same-cycle event");
endmodule : fsr_irq_ctrl

// ===== hw/fsr_status_bank.sv
// Read-only FEC status bank with register port and lock- and corrected-block-event interrupt
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ns
module fsr_status_bank (
	input wire logic clk,
	input wire logic rst,
	input wire logic [fsr_pkg::ADDR_W-1:0] addr,
	input wire logic [fsr_pkg::DATA_W-1:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [fsr_pkg::DATA_W-1:0] rd_data,
	output logic irq,
	input wire logic [fsr_pkg::F1_W-1:0] freq1_in,
	input wire logic [fsr_pkg::F2_W-1:0] freq2_in,
	input wire logic [fsr_pkg::SQ_W-1:0] quality_in,
	input wire logic [fsr_pkg::RATE_W-1:0] rate_in,
	input wire logic [fsr_pkg::RSCNT_W-1:0] rs_count_in,
	input wire logic block_done,
	input wire logic node_sync_in,
	input wire logic frame_sync_in,
	input wire logic byte_sync_in
);
	logic [fsr_pkg::F1_W-1:0] freq1_r;
	logic [fsr_pkg::F2_W-1:0] freq2_r;
	logic [fsr_pkg::SQ_W-1:0] qual_r;
	logic [fsr_pkg::F1_W-1:0] f1_sh_r;
	logic [fsr_pkg::F2_W-1:0] f2_sh_r;
	logic [fsr_pkg::SQ_W-1:0] sq_sh_r;
	logic [fsr_pkg::RATE_W-1:0] rate_r;
	logic [fsr_pkg::RSCNT_W-1:0] rscnt_r;
	logic [fsr_pkg::RSCNT_W-1:0] rscnt_nxt;
	logic [fsr_pkg::LOCK_N-1:0] lock_r;
	logic [fsr_pkg::DATA_W-1:0] rd_data_r;
	logic [fsr_pkg::DATA_W-1:0] rd_nxt;
	logic [fsr_pkg::F2_W+fsr_pkg::F2_PAD_W-1:0] f2_word;
	logic [fsr_pkg::LOCK_N-1:0] lock_chg;
	logic [fsr_pkg::EVT_W-1:0] evt;
	logic [fsr_pkg::EVT_W-1:0] irq_status;
	logic [fsr_pkg::EVT_W-1:0] irq_enable;
	logic block_evt_r;
	logic rate_ok;
	logic rd_f1_hi;
	logic rd_f2_hi;
	logic rd_sq_hi;
	logic wr_irq_en;
	logic wr_irq_clr;

	assign rd_f1_hi = rd_en && (addr == fsr_pkg::OFS_F1_HI);
	assign rd_f2_hi = rd_en && (addr == fsr_pkg::OFS_F2_HI);
	assign rd_sq_hi = rd_en && (addr == fsr_pkg::OFS_SQ_HI);
	// Only the interrupt controls accept writes; bank offsets fall through
	assign wr_irq_en = wr_en && (addr == fsr_pkg::OFS_IRQ_EN);
	assign wr_irq_clr = wr_en && (addr == fsr_pkg::OFS_IRQ_CLR);

	// Live copies of the measurement values, refreshed every cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			freq1_r <= '0;
			freq2_r <= '0;
			qual_r <= '0;
		end else begin
			freq1_r <= freq1_in;
			freq2_r <= freq2_in;
			qual_r <= quality_in;
		end
	end

	// Reading a high byte freezes the rest of the word, so a byte-wise
	// read of a moving value is never torn between samples
	always_ff @(posedge clk) begin
		if (rst) begin
			f1_sh_r <= '0;
		end else if (rd_f1_hi) begin
			f1_sh_r <= freq1_r;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			f2_sh_r <= '0;
		end else if (rd_f2_hi) begin
			f2_sh_r <= freq2_r;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sq_sh_r <= '0;
		end else if (rd_sq_hi) begin
			sq_sh_r <= qual_r;
		end
	end

	// Reserved rate codes are dropped and the last valid rate is kept
	assign rate_ok = rate_in <= fsr_pkg::RATE_W'(fsr_pkg::FSR_RATE_7_8);

	always_ff @(posedge clk) begin
		if (rst) begin
			rate_r <= fsr_pkg::RATE_W'(fsr_pkg::FSR_RATE_1_2);
		end else if (rate_ok) begin
			rate_r <= rate_in;
		end
	end

	// A decoder can correct at most eight symbols; clamp any larger figure
	always_comb begin
		if (rs_count_in > fsr_pkg::RSCNT_MAX) begin
			rscnt_nxt = fsr_pkg::RSCNT_MAX;
		end else begin
			rscnt_nxt = rs_count_in;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rscnt_r <= fsr_pkg::RSCNT_ZERO;
		end else if (block_done) begin
			rscnt_r <= rscnt_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			block_evt_r <= 1'b0;
		end else begin
			block_evt_r <= block_done && (rscnt_nxt != fsr_pkg::RSCNT_ZERO);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			lock_r <= '0;
		end else begin
			lock_r[fsr_pkg::LOCK_NODE] <= node_sync_in;
			lock_r[fsr_pkg::LOCK_FRAME] <= frame_sync_in;
			lock_r[fsr_pkg::LOCK_BYTE] <= byte_sync_in;
		end
	end

	// Second frequency is left-aligned; the low nibble of its last byte is zero
	assign f2_word = {freq2_r, fsr_pkg::F2_PAD};

	always_comb begin
		rd_nxt = fsr_pkg::BYTE_ZERO;
		case (addr)
			fsr_pkg::OFS_F1_HI: begin
				rd_nxt = freq1_r[23:16];
			end
			fsr_pkg::OFS_F1_MID: begin
				rd_nxt = f1_sh_r[15:8];
			end
			fsr_pkg::OFS_F1_LO: begin
				rd_nxt = f1_sh_r[7:0];
			end
			fsr_pkg::OFS_F2_HI: begin
				rd_nxt = f2_word[23:16];
			end
			fsr_pkg::OFS_F2_MID: begin
				rd_nxt = f2_sh_r[11:4];
			end
			fsr_pkg::OFS_F2_LO: begin
				rd_nxt = {f2_sh_r[3:0], fsr_pkg::F2_PAD};
			end
			fsr_pkg::OFS_SQ_HI: begin
				rd_nxt = qual_r[23:16];
			end
			fsr_pkg::OFS_SQ_MID: begin
				rd_nxt = sq_sh_r[15:8];
			end
			fsr_pkg::OFS_SQ_LO: begin
				rd_nxt = sq_sh_r[7:0];
			end
			fsr_pkg::OFS_RATE: begin
				rd_nxt = {5'h00, rate_r};
			end
			fsr_pkg::OFS_RSCNT: begin
				rd_nxt = {4'h0, rscnt_r};
			end
			fsr_pkg::OFS_LOCK: begin
				rd_nxt = {5'h00, lock_r};
			end
			fsr_pkg::OFS_IRQ_STAT: begin
				rd_nxt = {4'h0, irq_status};
			end
			fsr_pkg::OFS_IRQ_EN: begin
				rd_nxt = {4'h0, irq_enable};
			end
			default: begin
				rd_nxt = fsr_pkg::BYTE_ZERO;
			end
		endcase
	end

	// Read data stands for exactly one cycle, zero otherwise
	always_ff @(posedge clk) begin
		if (rst) begin
			rd_data_r <= fsr_pkg::BYTE_ZERO;
		end else if (rd_en) begin
			rd_data_r <= rd_nxt;
		end else begin
			rd_data_r <= fsr_pkg::BYTE_ZERO;
		end
	end

	assign rd_data = rd_data_r;

	fsr_evt_detect #(
		.W(fsr_pkg::LOCK_N)
	) u_lock_evt (
		.clk(clk),
		.rst(rst),
		.lvl(lock_r),
		.chg(lock_chg)
	);

	assign evt = {block_evt_r, lock_chg};

	fsr_irq_ctrl #(
		.W(fsr_pkg::EVT_W)
	) u_irq (
		.clk(clk),
		.rst(rst),
		.evt(evt),
		.en_wr(wr_irq_en),
		.clr_wr(wr_irq_clr),
		.wdata(wr_data[fsr_pkg::EVT_W-1:0]),
		.status(irq_status),
		.enable(irq_enable),
		.irq(irq)
	);

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	f1_high_read_a: assert property (
		rd_f1_hi |=> rd_data == $past(freq1_r[23:16]))
		else $error("first frequency high byte wrong");
	f1_low_coherent_a: assert property (
		rd_f1_hi ##1 (rd_en && addr == fsr_pkg::OFS_F1_LO && !rd_f1_hi)
		|=> rd_data == $past(freq1_r[7:0], 2))
		else $error("first frequency low byte not from snapshot");
	f1_mid_snap_a: assert property (
		rd_f1_hi ##1 (rd_en && addr == fsr_pkg::OFS_F1_MID)
		|=> rd_data == $past(freq1_r[15:8], 2))
		else $error("first frequency middle byte not from snapshot");

	f2_high_read_a: assert property (
		rd_f2_hi |=> rd_data == $past(freq2_r[19:12]))
		else $error("second frequency high byte wrong");
	f2_pad_zero_a: assert property (
		rd_en && addr == fsr_pkg::OFS_F2_LO |=> rd_data[3:0] == 4'h0)
		else $error("second frequency pad bits not zero");
	f2_mid_snap_a: assert property (
		rd_f2_hi ##1 (rd_en && addr == fsr_pkg::OFS_F2_MID)
		|=> rd_data == $past(freq2_r[11:4], 2))
		else $error("second frequency middle byte not from snapshot");
	f2_low_snap_a: assert property (
		rd_f2_hi ##1 (rd_en && addr == fsr_pkg::OFS_F2_LO)
		|=> rd_data == {$past(freq2_r[3:0], 2), fsr_pkg::F2_PAD})
		else $error("second frequency low byte not from snapshot");

	sq_byte_walk_a: assert property (
		rd_sq_hi ##1 (rd_en && addr == fsr_pkg::OFS_SQ_MID)
		|=> rd_data == $past(qual_r[15:8], 2))
		else $error("quality middle byte not from snapshot");
	sq_high_read_a: assert property (
		rd_sq_hi |=> rd_data == $past(qual_r[23:16]))
		else $error("quality high byte wrong");
	sq_low_snap_a: assert property (
		rd_sq_hi ##1 (rd_en && addr == fsr_pkg::OFS_SQ_LO)
		|=> rd_data == $past(qual_r[7:0], 2))
		else $error("quality low byte not from snapshot");

	rate_code_range_a: assert property (
		rate_r <= 3'h4)
		else $error("code rate out of range");
	rate_follows_in_a: assert property (
		rate_in <= 3'h4 |=> rate_r == $past(rate_in))
		else $error("code rate did not follow decoder");
	rate_hold_a: assert property (
		rate_in > 3'h4 |=> $stable(rate_r))
		else $error("reserved code rate changed the rate");
	rate_read_a: assert property (
		rd_en && addr == fsr_pkg::OFS_RATE |=> rd_data == {5'h00, $past(rate_r)})
		else $error("code rate byte wrong");

	rs_count_max_a: assert property (
		block_done |=> rscnt_r == (($past(rs_count_in) > fsr_pkg::RSCNT_MAX)
		? fsr_pkg::RSCNT_MAX : $past(rs_count_in)))
		else $error("correction count wrong");
	rs_count_hold_a: assert property (
		!block_done |=> $stable(rscnt_r))
		else $error("correction count moved without block");
	rs_count_read_a: assert property (
		rd_en && addr == fsr_pkg::OFS_RSCNT |=> rd_data == {4'h0, $past(rscnt_r)})
		else $error("correction count byte wrong");
	block_evt_a: assert property (
		block_done && rs_count_in != 4'h0 |=> ##1 irq_status[fsr_pkg::EVT_BLOCK])
		else $error("corrected block did not set its status bit");

	node_lock_a: assert property (
		node_sync_in ##1 (rd_en && addr == fsr_pkg::OFS_LOCK)
		|=> rd_data[0])
		else $error("node sync not reported");
	frame_lock_a: assert property (
		$rose(frame_sync_in) |=> lock_r[1] ##0 !$past(lock_r[1]))
		else $error("frame sync not reported");
	byte_lock_a: assert property (
		!byte_sync_in |=> !lock_r[2])
		else $error("byte sync reported without lock");
	// Lock bits read zero for one cycle after reset, hence the reset guard
	lock_read_a: assert property (
		rd_en && addr == fsr_pkg::OFS_LOCK && !$past(rst) |=> rd_data == {5'h00,
		$past(byte_sync_in, 2), $past(frame_sync_in, 2), $past(node_sync_in, 2)})
		else $error("lock byte does not match the sync inputs");
	// Either edge of a lock level is an event, two cycles after the input moves
	lock_evt_a: assert property (
		lock_chg == ($past(lock_r) ^ $past(lock_r, 2)))
		else $error("lock change event wrong");

	write_no_effect_a: assert property (
		wr_en |=> $stable(f1_sh_r) && $stable(f2_sh_r) && $stable(sq_sh_r)
		&& rd_data == 8'h00)
		else $error("write disturbed the bank");
	wr_keeps_enable_a: assert property (
		wr_en && addr != fsr_pkg::OFS_IRQ_EN |=> $stable(irq_enable))
		else $error("write outside enable register moved the mask");
	rd_idle_zero_a: assert property (
		!rd_en |=> rd_data == fsr_pkg::BYTE_ZERO)
		else $error("read data stood without a read");

	f1_byte_walk_c: cover property (
		rd_f1_hi ##1 (rd_en && addr == fsr_pkg::OFS_F1_MID)
		##1 (rd_en && addr == fsr_pkg::OFS_F1_LO));
	full_block_c: cover property (block_done && rs_count_in == 4'h8);
	all_locked_c: cover property (lock_r == 3'h7);
	irq_raised_c: cover property ($rose(irq));
	snap_clear_c: cover property (wr_irq_clr && evt != 4'h0);
endmodule : fsr_status_bank

// ===== testbench/fsr_status_bank_test.sv
// Self-checking bench for the FEC status readback bank
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module fsr_status_bank_test;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wr_data = 8'h00;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [7:0] rd_data;
	logic irq;
	logic [23:0] freq1_in = 24'h000000;
	logic [19:0] freq2_in = 20'h00000;
	logic [23:0] quality_in = 24'h000000;
	logic [2:0] rate_in = 3'h0;
	logic [3:0] rs_count_in = 4'h0;
	logic block_done = 1'b0;
	logic node_sync_in = 1'b0;
	logic frame_sync_in = 1'b0;
	logic byte_sync_in = 1'b0;
	int error_cnt = 0;
	int n_checks = 0;
	int cyc = 0;
	logic [71:0] bank_exp;
	logic [7:0] d;
	logic [3:0] st_exp;
	logic [3:0] en_exp;
	logic [2:0] lk_old;
	logic [2:0] lk_new;
	int rate_exp;
	int cnt_exp;
	int adr_q[$];

	fsr_status_bank u_dut (
		.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
		.rd_en(rd_en), .rd_data(rd_data), .irq(irq), .freq1_in(freq1_in),
		.freq2_in(freq2_in), .quality_in(quality_in), .rate_in(rate_in),
		.rs_count_in(rs_count_in), .block_done(block_done), .node_sync_in(node_sync_in),
		.frame_sync_in(frame_sync_in), .byte_sync_in(byte_sync_in)
	);

	always #50 clk = ~clk;

	// Ceiling well above the roughly 470 cycles the tests need
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			results();
		end
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wr_data <= v;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe, so sample just past that edge
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 v = rd_data;
	endtask : rd

	// High byte first, reads back to back; skip_mid puts each low byte right after its high byte
	task automatic chk_bank(input bit skip_mid);
		int k;
		adr_q.delete();
		for (int j = 0; j < 9; j++) begin
			if (!(skip_mid && j % 3 == 1)) begin
				adr_q.push_back(j);
			end
		end
		@(posedge clk);
		addr <= 8'h10 + 8'(adr_q[0]);
		rd_en <= 1'b1;
		while (adr_q.size() > 0) begin
			k = adr_q.pop_front();
			@(posedge clk);
			if (adr_q.size() > 0) begin
				addr <= 8'h10 + 8'(adr_q[0]);
			end else begin
				rd_en <= 1'b0;
			end
			#1 `CHK(rd_data, bank_exp[71-8*k -: 8])
		end
	endtask : chk_bank

	task automatic set_lock(input logic [2:0] v);
		@(posedge clk);
		node_sync_in <= v[0];
		frame_sync_in <= v[1];
		byte_sync_in <= v[2];
	endtask : set_lock

	task automatic results();
		$display("checks=%0d errors=%0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : results

	initial begin
		void'($urandom(20));
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		bank_exp = '0;
		chk_bank(1'b0);
		rd(fsr_pkg::OFS_LOCK, d);
		`CHK(d, 8'h00)
		rd(fsr_pkg::OFS_IRQ_STAT, d);
		`CHK(d, 8'h00)
		$display("test reset done");

		for (int n = 0; n < 4; n++) begin
			@(posedge clk);
			freq1_in <= 24'($urandom);
			freq2_in <= 20'($urandom);
			quality_in <= 24'($urandom);
			repeat (3) @(posedge clk);
			bank_exp = {freq1_in, freq2_in, 4'h0, quality_in};
			chk_bank(1'b0);
			@(posedge clk);
			#1 `CHK(rd_data, 8'h00)
			for (int k = 0; k < 12; k++) begin
				wr(8'h10 + 8'(k), 8'($urandom));
			end
			wr(fsr_pkg::OFS_IRQ_STAT, 8'hff);
			chk_bank(1'b1);
			rd(fsr_pkg::OFS_IRQ_STAT, d);
			`CHK(d, 8'h00)
		end
		rd(8'h30, d);
		`CHK(d, 8'h00)
		rd(fsr_pkg::OFS_IRQ_CLR, d);
		`CHK(d, 8'h00)
		$display("test values done");

		rate_exp = 0;
		for (int r = 0; r < 8; r++) begin
			@(posedge clk);
			rate_in <= 3'(r);
			if (r <= 4) rate_exp = r;
			repeat (2) @(posedge clk);
			rd(fsr_pkg::OFS_RATE, d);
			`CHK(d, 8'(rate_exp))
		end
		$display("test rate done");

		en_exp = 4'hf;
		wr(fsr_pkg::OFS_IRQ_EN, 8'h0f);
		for (int c = 0; c < 10; c++) begin
			wr(fsr_pkg::OFS_IRQ_CLR, 8'h0f);
			@(posedge clk);
			rs_count_in <= 4'(c);
			block_done <= 1'b1;
			@(posedge clk);
			block_done <= 1'b0;
			repeat (3) @(posedge clk);
			cnt_exp = (c > 8) ? 8 : c;
			rd(fsr_pkg::OFS_RSCNT, d);
			`CHK(d, 8'(cnt_exp))
			rd(fsr_pkg::OFS_IRQ_STAT, d);
			`CHK(d, {4'h0, (c != 0), 3'h0})
			`CHK(irq, (c != 0))
		end
		$display("test corrections done");

		lk_old = 3'h0;
		for (int i = 0; i < 5; i++) begin
			lk_new = (i < 3) ? 3'(1 << i) : ((i == 3) ? 3'h7 : 3'h0);
			en_exp = (i == 1) ? 4'h0 : 4'hf;
			wr(fsr_pkg::OFS_IRQ_EN, {4'h0, en_exp});
			wr(fsr_pkg::OFS_IRQ_CLR, 8'h0f);
			set_lock(lk_new);
			@(posedge clk);
			wr(fsr_pkg::OFS_IRQ_CLR, 8'h0f); // Clear meets the lock event: the event wins
			st_exp = {1'b0, lk_old ^ lk_new};
			rd(fsr_pkg::OFS_LOCK, d);
			`CHK(d, {5'h00, lk_new})
			rd(fsr_pkg::OFS_IRQ_STAT, d);
			`CHK(d, {4'h0, st_exp})
			rd(fsr_pkg::OFS_IRQ_EN, d);
			`CHK(d, {4'h0, en_exp})
			`CHK(irq, |(st_exp & en_exp))
			wr(fsr_pkg::OFS_IRQ_CLR, 8'h0f);
			@(posedge clk);
			#1 `CHK(irq, 1'b0)
			lk_old = lk_new;
		end
		$display("test locks done");
		results();
	end
endmodule : fsr_status_bank_test
